// >>> shared/opt_avg_pkg.sv
package opt_avg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_GX1 = 8'h00;
	localparam logic [7:0] ADDR_PY = 8'h06;
	localparam logic [7:0] ADDR_RSVD_DATA = 8'h07;
	localparam logic [7:0] ADDR_PART_ID = 8'h08;
	localparam logic [7:0] ADDR_TARGET = 8'h09;
	localparam logic [7:0] ADDR_OSC_CAL = 8'h0A;
	localparam logic [7:0] ADDR_TIMER_TEST = 8'h0C;
	localparam logic [7:0] ADDR_SOFT_RST = 8'h0F;
	localparam logic [7:0] ADDR_MOTION_PULSE = 8'h21;
	localparam logic [7:0] ADDR_MOTION_OFFSET = 8'h22;
	localparam logic [7:0] ADDR_PRES_PULSE = 8'h23;
	localparam logic [7:0] ADDR_PRES_OFFSET = 8'h24;
	localparam logic [7:0] ADDR_EMIT_ON = 8'h25;
	localparam logic [7:0] ADDR_CAL_CTRL = 8'h30;
	localparam logic [7:0] ADDR_SAMPLE_FREQ = 8'h40;
	localparam logic [7:0] ADDR_MODE = 8'h45;
	localparam logic [7:0] ADDR_AVG = 8'h46;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and widths
	localparam int PC_LSB = 8;
	localparam int PC_W = 6;
	localparam int PERIOD_LSB = 0;
	localparam int FREQ_MOTION_LSB = 0;
	localparam int FREQ_PRES_LSB = 4;
	localparam int AVG_MOTION_LSB = 4;
	localparam int AVG_PRES_LSB = 0;
	localparam int CAL_EN_BIT = 5;
	localparam int SOFT_RST_BIT = 0;
	localparam int TIMER_TEST_W = 5;
	localparam int CAL_W = 12;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] RST_RSVD_DATA = 16'h0020;
	localparam logic [15:0] RST_TARGET = 16'h00C8;
	localparam logic [4:0] RST_TIMER_TEST = 5'h0F;
	localparam logic [5:0] RST_PC = 6'h01;
	localparam logic [7:0] RST_PERIOD = 8'h13;
	localparam logic [7:0] RST_OFFSET = 8'h0A;
	localparam logic [7:0] RST_EMIT_ON = 8'h03;
	localparam logic [3:0] RST_FREQ = 4'h0;
	localparam logic [2:0] RST_AVG = 3'h0;
	localparam logic [3:0] RST_MODE = 4'hF;

	////////////////////////////////////////////////////////////////////////////
	// Modes, limits and sequencer states
	localparam logic [3:0] MODE_PRESENCE = 4'h1;
	localparam logic [3:0] MODE_MOTION = 4'h8;
	localparam logic [15:0] RESULT_MAX = 16'hFFFF;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WAIT = 3'b001,
		S_OFFSET = 3'b010,
		S_ON = 3'b011,
		S_GAP = 3'b100
	} seq_state_t;

endpackage : opt_avg_pkg

// >>> core/osc_cal_counter.sv
module osc_cal_counter #(
	parameter int CAL_W = 12
) (
	// Clock and combined reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control and slow oscillator pin
	input wire logic cal_en_i,
	input wire logic slow_osc_i,
	// Result
	output logic [CAL_W-1:0] cal_count_o
);

	////////////////////////////////////////////////////////////////////////////
	// Three-stage synchroniser, change accepted once stages two and three agree
	logic s1_q, s2_q, s3_q, lvl_q;
	logic [1:0] phase_q;
	logic [CAL_W-1:0] run_q;

	always_ff @(posedge clk_i) begin
		s1_q <= slow_osc_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	wire agree = (s2_q == s3_q);
	wire slow_rise = agree && s3_q && !lvl_q;
	wire window_end = slow_rise && (phase_q == 2'h2);

	// Filtered level of the slow clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= 1'b0;
		end else if (agree) begin
			lvl_q <= s3_q;
		end
	end

	// Count fast cycles across two slow periods, saturating; the middle rise keeps counting
	always_ff @(posedge clk_i) begin
		if (rst_i || !cal_en_i) begin
			phase_q <= 2'h0;
			run_q <= '0;
		end else begin
			if (slow_rise) begin
				phase_q <= window_end ? 2'h1 : phase_q + 2'h1;
			end
			if (slow_rise && phase_q != 2'h1) begin
				run_q <= '0;
			end else if (phase_q != 2'h0 && run_q != '1) begin
				run_q <= run_q + 1'b1;
			end
		end
	end

	// Result register holds until the next full window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_count_o <= '0;
		end else if (window_end) begin
			cal_count_o <= run_q + 1'b1;
		end
	end

	a_cal_window: assert property (@(posedge clk_i) disable iff (rst_i)
		window_end |=> cal_count_o == $past(run_q) + 1'b1)
		else $error("calibration count not taken at window end");
	a_cal_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!window_end && !rst_i |=> $stable(cal_count_o))
		else $error("calibration count moved outside a window end");

endmodule : osc_cal_counter

// >>> core/optical_sample_averaging_regs.sv
module optical_sample_averaging_regs #(
	parameter int SLOT_BASE_CYC = 25_000_000,
	parameter int SLOT_W = 25,
	parameter int ACC_W = 30,
	parameter logic [15:0] PART_ID = 16'h5A17 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Front-end conversions, one per channel
	input wire logic [15:0] afe_ch0_i,
	input wire logic [15:0] afe_ch1_i,
	input wire logic [15:0] afe_ch2_i,
	input wire logic [15:0] afe_ch3_i,
	// Slow oscillator pin
	input wire logic slow_osc_i,
	// Emitter drive and update strobe
	output logic led_on_o,
	output logic sample_ready_o
);

	localparam int TW = 13;
	localparam int CW = 14;

	////////////////////////////////////////////////////////////////////////////
	// Reset and register decode
	logic soft_rst_q;
	wire sys_rst = !rst_n_i || soft_rst_q;

	function automatic logic wr_at(input logic [7:0] a);
		return reg_wr_i && (reg_addr_i == a);
	endfunction : wr_at

	function automatic logic [TW-1:0] m1(input logic [TW-1:0] v);
		return (v == '0) ? '0 : v - 1'b1;
	endfunction : m1

	function automatic logic [15:0] sat16(input logic [ACC_W+1:0] v);
		return (v > (ACC_W+2)'(opt_avg_pkg::RESULT_MAX)) ? opt_avg_pkg::RESULT_MAX : v[15:0];
	endfunction : sat16

	// Soft reset pulse, self-clearing
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= wr_at(opt_avg_pkg::ADDR_SOFT_RST)
				&& reg_wdata_i[opt_avg_pkg::SOFT_RST_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [5:0] pc_m_q, pc_p_q;
	logic [7:0] per_m_q, per_p_q, off_m_q, off_p_q, emit_on_q;
	logic [3:0] freq_m_q, freq_p_q, mode_q;
	logic [2:0] avg_m_q, avg_p_q;
	logic [4:0] ttest_q;
	logic cal_en_q;

	// Writable fields; read-only offsets have no write path
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			pc_m_q <= opt_avg_pkg::RST_PC;
			pc_p_q <= opt_avg_pkg::RST_PC;
			per_m_q <= opt_avg_pkg::RST_PERIOD;
			per_p_q <= opt_avg_pkg::RST_PERIOD;
			off_m_q <= opt_avg_pkg::RST_OFFSET;
			off_p_q <= opt_avg_pkg::RST_OFFSET;
			emit_on_q <= opt_avg_pkg::RST_EMIT_ON;
			freq_m_q <= opt_avg_pkg::RST_FREQ;
			freq_p_q <= opt_avg_pkg::RST_FREQ;
			mode_q <= opt_avg_pkg::RST_MODE;
			avg_m_q <= opt_avg_pkg::RST_AVG;
			avg_p_q <= opt_avg_pkg::RST_AVG;
			ttest_q <= opt_avg_pkg::RST_TIMER_TEST;
			cal_en_q <= 1'b0;
		end else begin
			if (wr_at(opt_avg_pkg::ADDR_MOTION_PULSE)) begin
				pc_m_q <= reg_wdata_i[opt_avg_pkg::PC_LSB +: opt_avg_pkg::PC_W];
				per_m_q <= reg_wdata_i[opt_avg_pkg::PERIOD_LSB +: 8];
			end
			if (wr_at(opt_avg_pkg::ADDR_PRES_PULSE)) begin
				pc_p_q <= reg_wdata_i[opt_avg_pkg::PC_LSB +: opt_avg_pkg::PC_W];
				per_p_q <= reg_wdata_i[opt_avg_pkg::PERIOD_LSB +: 8];
			end
			if (wr_at(opt_avg_pkg::ADDR_MOTION_OFFSET)) begin
				off_m_q <= reg_wdata_i[7:0];
			end
			if (wr_at(opt_avg_pkg::ADDR_PRES_OFFSET)) begin
				off_p_q <= reg_wdata_i[7:0];
			end
			if (wr_at(opt_avg_pkg::ADDR_EMIT_ON)) begin
				emit_on_q <= reg_wdata_i[7:0];
			end
			if (wr_at(opt_avg_pkg::ADDR_SAMPLE_FREQ)) begin
				freq_m_q <= reg_wdata_i[opt_avg_pkg::FREQ_MOTION_LSB +: 4];
				freq_p_q <= reg_wdata_i[opt_avg_pkg::FREQ_PRES_LSB +: 4];
			end
			if (wr_at(opt_avg_pkg::ADDR_AVG)) begin
				avg_m_q <= reg_wdata_i[opt_avg_pkg::AVG_MOTION_LSB +: 3];
				avg_p_q <= reg_wdata_i[opt_avg_pkg::AVG_PRES_LSB +: 3];
			end
			if (wr_at(opt_avg_pkg::ADDR_MODE)) begin
				mode_q <= reg_wdata_i[3:0];
			end
			if (wr_at(opt_avg_pkg::ADDR_TIMER_TEST)) begin
				ttest_q <= reg_wdata_i[opt_avg_pkg::TIMER_TEST_W-1:0];
			end
			if (wr_at(opt_avg_pkg::ADDR_CAL_CTRL)) begin
				cal_en_q <= reg_wdata_i[opt_avg_pkg::CAL_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode-dependent selection
	wire is_motion = (mode_q == opt_avg_pkg::MODE_MOTION);
	wire active = is_motion || (mode_q == opt_avg_pkg::MODE_PRESENCE);
	wire [5:0] sel_pc = is_motion ? pc_m_q : pc_p_q;
	wire [5:0] pc_eff = (sel_pc == 6'h00) ? 6'h01 : sel_pc;
	wire [2:0] sel_avg = is_motion ? avg_m_q : avg_p_q;
	wire [6:0] n_m1 = 7'((8'h01 << sel_avg) - 8'h01);
	wire [7:0] n_samples = 8'h01 << sel_avg;
	wire [3:0] sel_freq = is_motion ? freq_m_q : freq_p_q;
	wire [SLOT_W-1:0] slot_len = SLOT_W'(SLOT_BASE_CYC >> sel_freq);
	wire [TW-1:0] on_cyc = TW'(emit_on_q * opt_avg_pkg::CYC_PER_US);
	wire [TW-1:0] per_cyc = TW'((is_motion ? per_m_q : per_p_q) * opt_avg_pkg::CYC_PER_US);
	wire [TW-1:0] off_cyc = TW'((is_motion ? off_m_q : off_p_q) * opt_avg_pkg::CYC_PER_US);
	wire [TW-1:0] gap_cyc = (per_cyc > on_cyc) ? per_cyc - on_cyc : TW'(1);

	////////////////////////////////////////////////////////////////////////////
	// Slot timer and burst sequencer
	opt_avg_pkg::seq_state_t state_q, state_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic [SLOT_W-1:0] slot_cnt_q;
	logic [5:0] pulse_idx_q;
	logic [6:0] samp_idx_q;
	logic pub_q;

	wire slot_tick = active && (slot_cnt_q == slot_len - SLOT_W'(1));
	wire pulse_end = (state_q == opt_avg_pkg::S_ON) && (tmr_q == '0);
	wire last_pulse = pulse_end && (pulse_idx_q == pc_eff - 6'h01);
	wire last_sample = (samp_idx_q == n_m1);
	wire publish_d = last_pulse && last_sample;

	// Next state: offset, then on/gap pairs, until the count is reached
	always_comb begin
		state_d = state_q;
		tmr_d = m1(tmr_q);
		if (!active) begin
			state_d = opt_avg_pkg::S_IDLE;
		end else begin
			unique case (state_q)
				opt_avg_pkg::S_IDLE: state_d = opt_avg_pkg::S_WAIT;
				opt_avg_pkg::S_WAIT: if (slot_tick) begin
					state_d = opt_avg_pkg::S_OFFSET;
					tmr_d = m1(off_cyc);
				end
				opt_avg_pkg::S_OFFSET: if (tmr_q == '0) begin
					state_d = opt_avg_pkg::S_ON;
					tmr_d = m1(on_cyc);
				end
				opt_avg_pkg::S_ON: if (tmr_q == '0) begin
					state_d = last_pulse ? opt_avg_pkg::S_WAIT : opt_avg_pkg::S_GAP;
					tmr_d = m1(gap_cyc);
				end
				opt_avg_pkg::S_GAP: if (tmr_q == '0) begin
					state_d = opt_avg_pkg::S_ON;
					tmr_d = m1(on_cyc);
				end
				default: state_d = opt_avg_pkg::S_IDLE;
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			state_q <= opt_avg_pkg::S_IDLE;
			tmr_q <= '0;
			led_on_o <= 1'b0;
			pub_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			led_on_o <= (state_d == opt_avg_pkg::S_ON);
			pub_q <= publish_d;
		end
	end

	// Slot, pulse and sample counters
	always_ff @(posedge clk_i) begin
		if (sys_rst || !active) begin
			slot_cnt_q <= '0;
			pulse_idx_q <= '0;
			samp_idx_q <= '0;
		end else begin
			slot_cnt_q <= slot_tick ? '0 : slot_cnt_q + 1'b1;
			if (last_pulse) begin
				pulse_idx_q <= '0;
				samp_idx_q <= last_sample ? 7'h00 : samp_idx_q + 7'h01;
			end else if (pulse_end) begin
				pulse_idx_q <= pulse_idx_q + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulation over every pulse of every combined sample
	logic [15:0] ch [4];
	logic [ACC_W-1:0] acc_q [4];
	logic [15:0] res_q [7];
	logic [15:0] pub_val [7];
	assign ch[0] = afe_ch0_i;
	assign ch[1] = afe_ch1_i;
	assign ch[2] = afe_ch2_i;
	assign ch[3] = afe_ch3_i;

	genvar g;
	for (g = 0; g < 4; g++) begin : g_acc
		always_ff @(posedge clk_i) begin
			if (sys_rst || !active || pub_q) begin
				acc_q[g] <= '0;
			end else if (pulse_end) begin
				acc_q[g] <= acc_q[g] + ACC_W'(ch[g]);
			end
		end
		assign pub_val[g] = sat16((ACC_W+2)'(acc_q[g]));
	end

	// Presence results: intensity, x and y from channel pairs
	assign pub_val[4] = sat16((ACC_W+2)'(acc_q[0]) + (ACC_W+2)'(acc_q[1])
		+ (ACC_W+2)'(acc_q[2]) + (ACC_W+2)'(acc_q[3]));
	assign pub_val[5] = sat16((ACC_W+2)'(acc_q[0]) + (ACC_W+2)'(acc_q[1]));
	assign pub_val[6] = sat16((ACC_W+2)'(acc_q[2]) + (ACC_W+2)'(acc_q[3]));

	// All results of the active mode load on the same edge
	for (g = 0; g < 7; g++) begin : g_res
		always_ff @(posedge clk_i) begin
			if (sys_rst) begin
				res_q[g] <= '0;
			end else if (pub_q && ((g < 4) == is_motion)) begin
				res_q[g] <= pub_val[g];
			end
		end
	end

	// Update strobe, high in the first cycle new results are visible
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			sample_ready_o <= 1'b0;
		end else begin
			sample_ready_o <= pub_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator calibration and read port
	logic [opt_avg_pkg::CAL_W-1:0] cal_count;

	osc_cal_counter #(.CAL_W(opt_avg_pkg::CAL_W)) u_cal (
		.clk_i(clk_i),
		.rst_i(sys_rst),
		.cal_en_i(cal_en_q),
		.slow_osc_i(slow_osc_i),
		.cal_count_o(cal_count)
	);

	// Read decode; reserved words return their defaults
	function automatic logic [15:0] rd_word(input logic [7:0] a);
		if (a <= opt_avg_pkg::ADDR_PY) begin
			return res_q[a[2:0]];
		end
		case (a)
			opt_avg_pkg::ADDR_RSVD_DATA: return opt_avg_pkg::RST_RSVD_DATA;
			opt_avg_pkg::ADDR_PART_ID: return PART_ID;
			opt_avg_pkg::ADDR_TARGET: return opt_avg_pkg::RST_TARGET;
			opt_avg_pkg::ADDR_OSC_CAL: return {4'h0, cal_count};
			opt_avg_pkg::ADDR_TIMER_TEST: return {11'h000, ttest_q};
			opt_avg_pkg::ADDR_SOFT_RST: return 16'h0000;
			opt_avg_pkg::ADDR_MOTION_PULSE: return {2'h0, pc_m_q, per_m_q};
			opt_avg_pkg::ADDR_PRES_PULSE: return {2'h0, pc_p_q, per_p_q};
			opt_avg_pkg::ADDR_MOTION_OFFSET: return {8'h00, off_m_q};
			opt_avg_pkg::ADDR_PRES_OFFSET: return {8'h00, off_p_q};
			opt_avg_pkg::ADDR_EMIT_ON: return {8'h00, emit_on_q};
			opt_avg_pkg::ADDR_CAL_CTRL: return 16'(cal_en_q) << opt_avg_pkg::CAL_EN_BIT;
			opt_avg_pkg::ADDR_SAMPLE_FREQ: return {8'h00, freq_p_q, freq_m_q};
			opt_avg_pkg::ADDR_MODE: return {12'h000, mode_q};
			opt_avg_pkg::ADDR_AVG: return {9'h000, avg_m_q, 1'b0, avg_p_q};
			default: return 16'h0000;
		endcase
	endfunction : rd_word

	// Registered read data, valid one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			reg_rdata_o <= '0;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rd_word(reg_addr_i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks and their helper counters
	logic [TW-1:0] led_len_q, off_len_q;
	logic [5:0] burst_pulses_q;
	logic [7:0] samp_seen_q;
	logic [CW-1:0] tally_q;
	logic [SLOT_W-1:0] tick_gap_q;
	logic tick_seen_q;
	logic led_prev_q;
	wire led_rise = led_on_o && !led_prev_q;

	always_ff @(posedge clk_i) begin
		if (sys_rst || !active) begin
			led_len_q <= '0;
			off_len_q <= '0;
			burst_pulses_q <= '0;
			samp_seen_q <= '0;
			tally_q <= '0;
			tick_gap_q <= '0;
			tick_seen_q <= 1'b0;
			led_prev_q <= 1'b0;
		end else begin
			led_len_q <= led_on_o ? led_len_q + 1'b1 : '0;
			off_len_q <= (state_q == opt_avg_pkg::S_OFFSET) ? off_len_q + 1'b1 : '0;
			burst_pulses_q <= (state_q == opt_avg_pkg::S_OFFSET) ? 6'h00
				: burst_pulses_q + 6'(led_rise);
			samp_seen_q <= pub_q ? 8'h00 : samp_seen_q + 8'(last_pulse);
			tally_q <= pub_q ? '0 : tally_q + CW'(led_rise);
			tick_gap_q <= slot_tick ? '0 : tick_gap_q + 1'b1;
			tick_seen_q <= tick_seen_q || slot_tick;
			led_prev_q <= led_on_o; // Idle level low, so no false edge after reset
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst);

	sequence s_soft_write;
		reg_wr_i && reg_addr_i == opt_avg_pkg::ADDR_SOFT_RST && reg_wdata_i[0];
	endsequence
	sequence s_burst_done;
		$fell(led_on_o) && state_q == opt_avg_pkg::S_WAIT;
	endsequence

	a_pulses_per_sample: assert property (s_burst_done |-> burst_pulses_q == pc_eff)
		else $error("burst pulse count differs from setting");
	a_output_rate: assert property (pub_q |-> samp_seen_q == n_samples)
		else $error("output not after N internal samples");
	a_pulse_total: assert property (pub_q |-> tally_q == CW'(pc_eff) * CW'(n_samples))
		else $error("total pulses per output wrong");
	a_slot_period: assert property (slot_tick && tick_seen_q |-> tick_gap_q == slot_len - 1'b1)
		else $error("slot period does not match frequency field");
	a_start_offset: assert property ($rose(led_on_o) && $past(state_q) == opt_avg_pkg::S_OFFSET
		|-> $past(off_len_q) + 1'b1 == ((off_cyc == '0) ? TW'(1) : off_cyc))
		else $error("start offset length wrong");
	a_led_on_time: assert property ($fell(led_on_o)
		|-> led_len_q == ((on_cyc == '0) ? TW'(1) : on_cyc))
		else $error("emitter on-time wrong");
	a_sat_result: assert property (pub_q && is_motion && acc_q[0] > ACC_W'(16'hFFFF)
		|=> res_q[0] == opt_avg_pkg::RESULT_MAX)
		else $error("result wrapped instead of saturating");
	a_sat_presence: assert property (pub_q && !is_motion
		&& (ACC_W+1)'(acc_q[0]) + (ACC_W+1)'(acc_q[1]) > (ACC_W+1)'(opt_avg_pkg::RESULT_MAX)
		|=> res_q[5] == opt_avg_pkg::RESULT_MAX)
		else $error("presence result wrapped instead of saturating");
	a_results_atomic: assert property ($changed(res_q[0]) || $changed(res_q[4])
		|-> sample_ready_o || $past(sys_rst))
		else $error("results changed outside an update");
	a_reserved_read: assert property (reg_rd_i && reg_addr_i == opt_avg_pkg::ADDR_RSVD_DATA
		|=> reg_rvalid_o && reg_rdata_o == opt_avg_pkg::RST_RSVD_DATA)
		else $error("reserved word did not read default");
	a_soft_reset: assert property (disable iff (!rst_n_i) s_soft_write |=> soft_rst_q
		##1 (state_q == opt_avg_pkg::S_IDLE && mode_q == opt_avg_pkg::RST_MODE && !led_on_o))
		else $error("soft reset did not restore defaults");

endmodule : optical_sample_averaging_regs

// >>> test/front_end_model.sv
module front_end_model #(
	parameter int SLOW_HALF = 30
) (
	// Clock
	input wire logic clk_i,
	// Light level seen by the photodiodes
	input wire logic [15:0] level_i,
	// Channel conversions and slow oscillator
	output logic [15:0] ch0_o,
	output logic [15:0] ch1_o,
	output logic [15:0] ch2_o,
	output logic [15:0] ch3_o,
	output logic slow_osc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int half_cnt = 0;

	// Each channel offset by its index so a swapped channel shows
	assign ch0_o = level_i;
	assign ch1_o = level_i + 16'h0100;
	assign ch2_o = level_i + 16'h0200;
	assign ch3_o = level_i + 16'h0300;

	// Free-running slow oscillator, phase unrelated to any request
	initial begin
		slow_osc_o = 1'b0;
		forever begin
			@(posedge clk_i);
			half_cnt++;
			if (half_cnt == SLOW_HALF) begin
				half_cnt = 0;
				slow_osc_o <= ~slow_osc_o;
			end
		end
	end
endmodule : front_end_model

// >>> test/optical_sample_averaging_regs_test.sv
module optical_sample_averaging_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] PART_ID = 16'h3C5A; // Arbitrary value
	localparam int LIMIT = 20000;
	logic clk_i = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic [15:0] level = 16'h0100;
	logic [15:0] ch0, ch1, ch2, ch3;
	logic slow_osc, led_on, sample_ready, led_q;
	logic [15:0] got;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int gap = 0, last_gap = 0, pulses = 0, last_pulses = 0, on_cnt = 0, width = 0;
	logic [7:0] rst_addr [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
		8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0F, 8'h21};
	logic [15:0] rst_val [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0020, PART_ID, 16'h00C8, 16'h0000, 16'h0000, 16'h000F,
		16'h0000, 16'h0113};

	////////////////////////////////////////////////////////////////////////////
	// Design and front end
	optical_sample_averaging_regs #(.SLOT_BASE_CYC(400), .PART_ID(PART_ID)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.reg_rvalid_o(reg_rvalid), .afe_ch0_i(ch0), .afe_ch1_i(ch1), .afe_ch2_i(ch2),
		.afe_ch3_i(ch3), .slow_osc_i(slow_osc), .led_on_o(led_on),
		.sample_ready_o(sample_ready));
	front_end_model #(.SLOW_HALF(30)) fe (.clk_i(clk_i), .level_i(level), .ch0_o(ch0),
		.ch1_o(ch1), .ch2_o(ch2), .ch3_o(ch3), .slow_osc_o(slow_osc));

	////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and emitter monitor
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_errors++;
			print_verdict();
		end
	end

	// Pulses and cycles between output updates, width of each pulse
	always @(negedge clk_i) begin
		if (sample_ready === 1'b1) begin
			last_gap = gap;
			last_pulses = pulses;
			gap = 1;
			pulses = 0;
		end else begin
			gap++;
		end
		if (led_on === 1'b1) begin
			on_cnt++;
			if (led_q !== 1'b1) pulses++;
		end else if (led_q === 1'b1) begin
			width = on_cnt;
			on_cnt = 0;
		end
		led_q = led_on;
	end

	////////////////////////////////////////////////////////////////////////////
	// Access tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_i);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_i);
		reg_wr = 1'b0;
	endtask : wr

	// Read answers one cycle after the request edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_i);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_i);
		reg_rd = 1'b0;
		chk({15'h0000, reg_rvalid}, 16'h0001);
		d = reg_rdata;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rdc

	// Two update strobes, so the second gap is a full output period
	task automatic wait_two;
		int i;
		i = 0;
		repeat (2) begin
			@(negedge clk_i);
			while (sample_ready !== 1'b1 && i < 3000) begin
				@(negedge clk_i);
				i++;
			end
		end
		@(posedge clk_i); // Let the edge monitor finish this strobe first
		chk(16'(i < 3000), 16'h0001);
	endtask : wait_two

	task automatic print_verdict;
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (10) @(negedge clk_i);
		rst_n = 1'b1;
		for (int k = 0; k < 15; k++) begin
			rdc(rst_addr[k], rst_val[k]);
		end
		// Read-only places keep their value
		for (int k = 7; k < 11; k++) begin
			wr(rst_addr[k], 16'hFFFF);
			rdc(rst_addr[k], rst_val[k]);
		end
		// Motion: 3 pulses per sample, 2 samples per output, 200-cycle slots
		wr(8'h25, 16'h0001);
		wr(8'h22, 16'h0001);
		wr(8'h21, 16'h0302);
		wr(8'h46, 16'h0010);
		wr(8'h40, 16'h0001);
		wr(8'h45, 16'h0008);
		wait_two();
		chk(16'(last_gap), 16'd400);
		chk(16'(last_pulses), 16'd6);
		chk(16'(width), 16'(opt_avg_pkg::CYC_PER_US));
		wr(8'h45, 16'h000F);
		for (int k = 0; k < 4; k++) begin
			rdc(8'(k), 16'((k + 1) * 16'h0600));
		end
		wr(8'h00, 16'hABCD);
		rdc(8'h00, 16'h0600);
		// Presence with a bright level: every presence result clips
		level = 16'hF000;
		wr(8'h23, 16'h0202);
		wr(8'h24, 16'h0001);
		wr(8'h40, 16'h0000);
		wr(8'h46, 16'h0000);
		wr(8'h45, 16'h0001);
		wait_two();
		chk(16'(last_gap), 16'd400);
		chk(16'(last_pulses), 16'd2);
		wr(8'h45, 16'h000F);
		for (int k = 4; k < 7; k++) begin
			rdc(8'(k), 16'hFFFF);
		end
		rdc(8'h01, 16'h0C00);
		// Calibration over two slow periods of 60 cycles
		wr(8'h30, 16'h0020);
		repeat (600) @(negedge clk_i);
		rd(8'h0A, got);
		chk(16'(got >= 16'd119 && got <= 16'd121), 16'h0001);
		// Soft reset brings back every default
		wr(8'h0C, 16'h0015);
		rdc(8'h0C, 16'h0015);
		wr(8'h0F, 16'h0001);
		repeat (2) @(negedge clk_i);
		for (int k = 0; k < 15; k++) begin
			rdc(rst_addr[k], rst_val[k]);
		end
		print_verdict();
	end
endmodule : optical_sample_averaging_regs_test
